// ### hw/csd_pkg.sv
// constants, types and shared functions for the card supply converter control
package csd_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 8;
   localparam logic [7:0]  OFS_DCDC_CONTROL = 8'hbf;
   localparam logic [7:0]  OFS_IFACE_CTRL   = 8'hc2;
   localparam logic [7:0]  OFS_CARD_CTRL    = 8'hc3;
   localparam logic [7:0]  OFS_IFACE_STATUS = 8'hc4;
   localparam logic [7:0]  OFS_INT_STATUS   = 8'hc5;
   localparam logic [7:0]  OFS_INT_MASK     = 8'hc6;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          MODE_BIT         = 7;
   localparam int          RAISE_BIT        = 6;
   localparam int          BOOST_LSB        = 4;
   localparam int          DIV_LSB          = 0;
   localparam int          LEVEL_LSB        = 0;
   localparam int          SWITCH_BIT       = 0;
   localparam int          READY_BIT        = 0;
   localparam int          OVF_BIT          = 1;
   localparam int          EV_READY         = 0;
   localparam int          EV_OVC           = 1;
   localparam int          EV_REMOVED       = 2;
   localparam int          EV_W             = 3;
   localparam logic [7:0]  DCDC_RST         = 8'h00;
   localparam logic [1:0]  LEVEL_RST        = 2'h0;
   localparam logic [2:0]  INT_RST          = 3'h0;

   // ------------------------------------------------------------
   // currents and timing
   // ------------------------------------------------------------
   localparam logic [8:0]  NOMINAL_LIMIT_MA = 9'h064;   // 100 mA
   localparam logic [8:0]  RAISED_LIMIT_MA  = 9'h078;   // 120 mA
   localparam logic [8:0]  STARTUP_MA       = 9'h01e;   // 30 mA
   localparam int          CLK_MHZ          = 100;
   localparam int          SHUTDOWN_NS      = 1000;
   localparam int          SHUTDOWN_CYCLES  = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
   localparam int          SHUT_W           = 8;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_OFF   = 4'h1,
      ST_START = 4'h2,
      ST_RUN   = 4'h4,
      ST_STOP  = 4'h8
   } csd_state_type;

   typedef struct packed {
      logic       enable;
      logic       regulator_mode;
      logic [1:0] level;
      logic [8:0] startup_ma;
      logic [8:0] limit_ma;
      logic       sense_en;
   } csd_conv_ctl_type;

   typedef struct packed {
      logic card_present;
      logic overcurrent;
      logic voltage_ok;
   } csd_sense_type;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // scale a current by the boost code: +0%, +30%, +50%, +30%
   function automatic logic [8:0] boost_scale(input logic [8:0] base, input logic [1:0] code);
      logic [12:0] prod;
      prod = 13'h0;
      unique case (code)
         2'h0: prod = {4'h0, base} * 13'h00a;
         2'h1: prod = {4'h0, base} * 13'h00d;
         2'h2: prod = {4'h0, base} * 13'h00f;
         2'h3: prod = {4'h0, base} * 13'h00d;
      endcase
      return 9'(prod / 13'h00a);
   endfunction

   // prescaler code to division factor
   function automatic logic [3:0] div_factor(input logic [3:0] code);
      logic [3:0] f;
      f = 4'hc;
      unique case (code)
         4'h0:    f = 4'h2;
         4'h1:    f = 4'h4;
         4'h2:    f = 4'h5;
         4'h3:    f = 4'h6;
         4'h4:    f = 4'h8;
         4'h5:    f = 4'ha;
         default: f = 4'hc;
      endcase
      return f;
   endfunction

endpackage

// ### hw/csd_clk_div.sv
// converter clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module csd_clk_div
   import csd_pkg::*;
#(
   parameter int CODE_W = 4
) (
   input  wire logic              clk,    // system clock
   input  wire logic              resetn, // async reset, active low
   input  wire logic              run,    // divider running
   input  wire logic [CODE_W-1:0] code,   // prescaler code
   output logic                   tick    // converter clock enable
);

   logic [3:0] cnt_q;
   logic [3:0] factor;

   assign factor = div_factor(4'(code));

   // -------------------------------------------
   // counter and tick
   // -------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 4'h0;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= 4'h0;
         tick  <= 1'b0;
      end else if (cnt_q >= factor - 4'h1) begin
         cnt_q <= 4'h0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         tick  <= 1'b0;
      end
   end

   tick_space_a: assert property (@(posedge clk) disable iff (!resetn) tick |=> !tick)
      else $error("converter tick on two cycles in a row");

endmodule
`default_nettype wire

// ### hw/csd_top.sv
// card supply converter control: registers, interlock, sequencing, status
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module csd_top
   import csd_pkg::*;
(
   input  wire logic              clk,              // system clock, 100 MHz
   input  wire logic              resetn,           // async reset, active low
   input  wire logic [ADDR_W-1:0] reg_addr,         // register address
   input  wire logic [DATA_W-1:0] reg_wdata,        // write data
   input  wire logic              reg_wr,           // write strobe
   input  wire logic              reg_rd,           // read strobe
   output logic [DATA_W-1:0]      reg_rdata,        // read data, cycle after strobe
   input  wire logic              card_presence_in, // card present pin, high = present
   input  wire logic              overcurrent_in,   // analog overcurrent comparator
   input  wire logic              voltage_ok_in,    // output inside its window
   output csd_conv_ctl_type       conv_ctl,         // controls to analog stage
   output logic                   conv_clk_tick,    // converter clock enable pulse
   output logic                   irq               // level interrupt
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0]       dcdc_control_q;
   logic [1:0]       card_level_select_q;
   logic             supply_switch_on_q;
   logic             supply_ready_flag_q;
   logic             overcurrent_flag_q;
   logic [EV_W-1:0]  int_status_q;
   logic [EV_W-1:0]  int_mask_q;
   logic [EV_W-1:0]  events;
   logic [SHUT_W-1:0] stop_cnt_q;
   csd_sense_type    sense_meta_q;
   csd_sense_type    sense_q;
   csd_state_type    state_q;
   csd_state_type    state_d;
   csd_conv_ctl_type conv_d;
   logic             wr_dcdc;
   logic             wr_iface;
   logic             wr_card;
   logic             wr_istat;
   logic             wr_imask;
   logic             stop_done;
   logic             ovc_trip;
   logic             removed;
   logic             ready_d;

   assign wr_dcdc  = reg_wr && (reg_addr == OFS_DCDC_CONTROL);
   assign wr_iface = reg_wr && (reg_addr == OFS_IFACE_CTRL);
   assign wr_card  = reg_wr && (reg_addr == OFS_CARD_CTRL);
   assign wr_istat = reg_wr && (reg_addr == OFS_INT_STATUS);
   assign wr_imask = reg_wr && (reg_addr == OFS_INT_MASK);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // two flops before any logic looks at the pins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sense_meta_q <= '0;
         sense_q      <= '0;
      end else begin
         sense_meta_q <= '{card_present: card_presence_in,
                           overcurrent:  overcurrent_in,
                           voltage_ok:   voltage_ok_in};
         sense_q      <= sense_meta_q;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   assign stop_done = (stop_cnt_q == SHUT_W'(SHUTDOWN_CYCLES - 1));
   // overcurrent only counts once the converter is up, card removal already counts during startup
   assign ovc_trip  = (state_q == ST_RUN) && sense_q.overcurrent;
   assign removed   = ((state_q == ST_RUN) || (state_q == ST_START)) && !sense_q.card_present;

   // next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_OFF: begin
            if (supply_switch_on_q && sense_q.card_present) begin
               state_d = ST_START;
            end
         end
         ST_START: begin
            if (removed || !supply_switch_on_q) begin
               state_d = ST_STOP;
            end else if (sense_q.voltage_ok) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (removed || ovc_trip || !supply_switch_on_q) begin
               state_d = ST_STOP;
            end
         end
         ST_STOP: begin
            if (stop_done) begin
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // shutdown discharge timer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stop_cnt_q <= '0;
      end else if (state_q == ST_STOP) begin
         stop_cnt_q <= stop_cnt_q + SHUT_W'(1);
      end else begin
         stop_cnt_q <= '0;
      end
   end

   // ------------------------------------------------------------
   // converter controls
   // ------------------------------------------------------------
   // registered so the analog stage sees clean levels
   always_comb begin
      conv_d                = '0;
      conv_d.enable         = (state_d == ST_START) || (state_d == ST_RUN);
      conv_d.regulator_mode = dcdc_control_q[MODE_BIT];
      conv_d.level          = card_level_select_q;
      conv_d.startup_ma     = boost_scale(STARTUP_MA, dcdc_control_q[BOOST_LSB +: 2]);
      conv_d.limit_ma       = boost_scale(dcdc_control_q[RAISE_BIT] ? RAISED_LIMIT_MA
                                          : NOMINAL_LIMIT_MA,
                                          dcdc_control_q[BOOST_LSB +: 2]);
      conv_d.sense_en       = (state_d == ST_RUN);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_ctl <= '0;
      end else begin
         conv_ctl <= conv_d;
      end
   end

   // converter clock prescaler
   csd_clk_div #(
      .CODE_W (4)
   ) u_clk_div (
      .clk    (clk),
      .resetn (resetn),
      .run    (conv_ctl.enable),
      .code   (dcdc_control_q[DIV_LSB +: 4]),
      .tick   (conv_clk_tick)
   );

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   assign ready_d = (state_d == ST_RUN) && sense_q.voltage_ok;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         supply_ready_flag_q <= 1'b0;
      end else begin
         supply_ready_flag_q <= ready_d;
      end
   end

   // set by an overcurrent shutdown, cleared by a fresh start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overcurrent_flag_q <= 1'b0;
      end else if (ovc_trip) begin
         overcurrent_flag_q <= 1'b1;
      end else if (state_d == ST_START) begin
         overcurrent_flag_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dcdc_control_q <= DCDC_RST;
      end else if (wr_dcdc) begin
         dcdc_control_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         card_level_select_q <= LEVEL_RST;
      end else if (wr_iface) begin
         card_level_select_q <= reg_wdata[LEVEL_LSB +: 2];
      end
   end

   // switch command drops when hardware shuts the converter down
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         supply_switch_on_q <= 1'b0;
      end else if (removed || ovc_trip) begin
         supply_switch_on_q <= 1'b0;
      end else if (wr_card) begin
         supply_switch_on_q <= reg_wdata[SWITCH_BIT];
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   always_comb begin
      events             = '0;
      events[EV_READY]   = ready_d && !supply_ready_flag_q;
      events[EV_OVC]     = ovc_trip;
      events[EV_REMOVED] = removed;
   end

   // sticky, write one to clear, a new event wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_status_q <= INT_RST;
      end else begin
         int_status_q <= (int_status_q & ~(wr_istat ? reg_wdata[EV_W-1:0] : INT_RST)) | events;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_mask_q <= INT_RST;
      end else if (wr_imask) begin
         int_mask_q <= reg_wdata[EV_W-1:0];
      end
   end

   assign irq = |(int_status_q & int_mask_q);

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_DCDC_CONTROL: reg_rdata <= dcdc_control_q;
            OFS_IFACE_CTRL:   reg_rdata <= {6'h00, card_level_select_q};
            OFS_CARD_CTRL:    reg_rdata <= {7'h00, supply_switch_on_q};
            OFS_IFACE_STATUS: reg_rdata <= {6'h00, overcurrent_flag_q, supply_ready_flag_q};
            OFS_INT_STATUS:   reg_rdata <= {5'h00, int_status_q};
            OFS_INT_MASK:     reg_rdata <= {5'h00, int_mask_q};
            default:          reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence card_gone_s;
      (state_q == ST_RUN || state_q == ST_START) && !sense_q.card_present;
   endsequence

   sequence shut_seq_s;
      (state_q == ST_STOP && !conv_ctl.enable) ##1 (state_q == ST_STOP);
   endsequence

   no_card_start_a: assert property (
      state_q == ST_OFF && !sense_q.card_present |=> !conv_ctl.enable && state_q == ST_OFF)
      else $error("converter enabled without a card");

   removal_stop_a: assert property (
      card_gone_s |=> shut_seq_s)
      else $error("card removal did not shut the converter down");

   mode_follow_a: assert property (
      ##1 conv_ctl.regulator_mode == $past(dcdc_control_q[MODE_BIT]))
      else $error("mode output differs from control bit 7");

   limit_value_a: assert property (
      $past(resetn) && $past(dcdc_control_q[BOOST_LSB +: 2]) == 2'h0 |->
      conv_ctl.limit_ma == ($past(dcdc_control_q[RAISE_BIT]) ? 9'h078 : 9'h064))
      else $error("overcurrent limit wrong for raise bit");

   ovc_flag_a: assert property (
      ovc_trip |=> overcurrent_flag_q && !supply_ready_flag_q && state_q == ST_STOP)
      else $error("overcurrent shutdown flags wrong");

   boost_start_a: assert property (
      $past(dcdc_control_q[BOOST_LSB +: 2]) == 2'h2 |-> conv_ctl.startup_ma == 9'h02d)
      else $error("startup current not raised by half");

   boost_limit_a: assert property (
      $past(dcdc_control_q[7:4]) == 4'h1 |-> conv_ctl.limit_ma == 9'h082)
      else $error("boost does not scale the limit");

   startup_quiet_a: assert property (
      state_q == ST_START |-> !conv_ctl.sense_en && !supply_ready_flag_q && !overcurrent_flag_q)
      else $error("flags or sensing active during startup");

   window_out_a: assert property (
      state_q == ST_RUN && !sense_q.voltage_ok && !sense_q.overcurrent
      |=> !supply_ready_flag_q && !overcurrent_flag_q)
      else $error("flags not cleared with output out of window");

   switch_start_a: assert property (
      state_q == ST_OFF && supply_switch_on_q && sense_q.card_present
      |=> state_q == ST_START && conv_ctl.enable)
      else $error("switch command did not start the converter");

endmodule
`default_nettype wire

// ### verif/csd_analog_model.sv
// behavioural model of the analog converter stage and the card presence switch
`timescale 1ns/1ps
`default_nettype none
module csd_analog_model
   import csd_pkg::*;
#(
   parameter int RAMP_CYCLES = 20
) (
   input  wire logic             clk,              // system clock
   input  wire logic             resetn,           // async reset, active low
   input  wire csd_conv_ctl_type conv_ctl,         // controls from the block
   input  wire logic             card_in,          // card inserted by bench
   input  wire logic [8:0]       load_ma,          // load current drawn
   input  wire logic             out_fault,        // output pushed out of window
   output logic                  card_presence_in, // presence switch
   output logic                  overcurrent_in,   // overcurrent comparator
   output logic                  voltage_ok_in     // output inside window
);
   int ramp_q;

   // ------------------------------------------------------------
   // output ramp
   // ------------------------------------------------------------
   // the output only climbs while the load fits the startup current
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ramp_q <= 0;
      end else if (!conv_ctl.enable) begin
         ramp_q <= 0;
      end else if (load_ma <= conv_ctl.startup_ma && ramp_q < RAMP_CYCLES) begin
         ramp_q <= ramp_q + 1;
      end
   end

   // comparator outputs
   assign card_presence_in = card_in;
   assign voltage_ok_in    = conv_ctl.enable && ramp_q == RAMP_CYCLES && !out_fault;
   assign overcurrent_in   = conv_ctl.enable && load_ma > conv_ctl.limit_ma;
endmodule
`default_nettype wire

// ### verif/card_supply_dcdc_control_bench.sv
// self-checking testbench of the card supply converter control
`timescale 1ns/1ps
`default_nettype none
module card_supply_dcdc_control_bench;
   import csd_pkg::*;
   logic             clk, resetn, reg_wr, reg_rd, card_in, out_fault, tick, irq;
   logic [7:0]       reg_addr, reg_wdata, reg_rdata, rd;
   logic [8:0]       load_ma;
   logic             pres, ovc, vok;
   csd_conv_ctl_type conv_ctl;
   int               fails, checks;

   // ------------------------------------------------------------
   // design, partner and clock
   // ------------------------------------------------------------
   csd_top dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_presence_in(pres),
      .overcurrent_in(ovc), .voltage_ok_in(vok), .conv_ctl(conv_ctl), .conv_clk_tick(tick), .irq(irq));
   csd_analog_model ana_u (.clk(clk), .resetn(resetn), .conv_ctl(conv_ctl), .card_in(card_in),
      .load_ma(load_ma), .out_fault(out_fault), .card_presence_in(pres), .overcurrent_in(ovc),
      .voltage_ok_in(vok));
   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // poll the status register as firmware does, bounded
   task automatic poll(input logic [7:0] exp);
      for (int i = 0; i < 60; i++) begin
         rdr(OFS_IFACE_STATUS);
         if (rd === exp) break;
      end
   endtask
   // switch off and let the shutdown finish
   task automatic power_off();
      wr(OFS_CARD_CTRL, 8'h00);
      repeat (120) @(posedge clk);
      wr(OFS_INT_STATUS, 8'h07);
   endtask
   // low card level in regulator mode, default prescaler
   task automatic start_ok();
      load_ma <= 9'h014; card_in <= 1'b1;
      wr(OFS_IFACE_CTRL, 8'h01);
      wr(OFS_DCDC_CONTROL, 8'h80);
      wr(OFS_CARD_CTRL, 8'h01);
      poll(8'h01);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdr(OFS_DCDC_CONTROL); check(rd, 8'h00, "dcdc reset");
      rdr(OFS_IFACE_STATUS); check(rd, 8'h00, "status reset");
      rdr(8'h10); check(rd, 8'h00, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_no_card();
      card_in <= 1'b0;
      wr(OFS_CARD_CTRL, 8'h01);
      repeat (40) @(posedge clk);
      #1 check(conv_ctl.enable, 1'b0, "enable without card");
      rdr(OFS_IFACE_STATUS); check(rd, 8'h00, "status without card");
      wr(OFS_CARD_CTRL, 8'h00);
      $display("test no card done");
   endtask
   task automatic t_fields();
      int m[4] = '{10, 13, 15, 13};
      for (int b = 0; b < 8; b++) begin
         wr(OFS_DCDC_CONTROL, {b[0], b[0], b[2:1], 4'h0});
         wr(OFS_IFACE_CTRL, {6'h00, b[2:1]});
         repeat (2) @(posedge clk);
         #1 check(conv_ctl.regulator_mode, b[0], "mode");
         check(conv_ctl.level, b[2:1], "level");
         check(conv_ctl.startup_ma, 9'(30 * m[b[2:1]] / 10), "startup");
         check(conv_ctl.limit_ma, 9'((b[0] ? 120 : 100) * m[b[2:1]] / 10), "limit");
      end
      wr(OFS_DCDC_CONTROL, 8'h00);
      $display("test fields done");
   endtask
   task automatic t_start_tick();
      int n;
      int f[7] = '{2, 4, 5, 6, 8, 10, 12};
      wr(OFS_INT_MASK, 8'h07);
      start_ok();
      check(rd, 8'h01, "ready running");
      #1 check(irq, 1'b1, "ready irq");
      wr(OFS_INT_STATUS, 8'h01);
      #1 check(irq, 1'b0, "irq cleared");
      // every prescaler code, the last one standing for all codes past 5
      for (int k = 0; k < 7; k++) begin
         wr(OFS_DCDC_CONTROL, {4'h8, (k < 6) ? 4'(k) : 4'hf});
         repeat (20) @(posedge clk);
         n = 0;
         repeat (120) begin
            @(posedge clk);
            #1 n += tick;
         end
         check(9'(n), 9'(120 / f[k]), "tick count");
      end
      wr(OFS_DCDC_CONTROL, 8'h80);
      wr(OFS_INT_MASK, 8'h05);
      load_ma <= 9'h0c8;
      poll(8'h02);
      check(rd, 8'h02, "overcurrent trip");
      #1 check(irq, 1'b0, "trip masked");
      wr(OFS_INT_MASK, 8'h07);
      #1 check(irq, 1'b1, "trip irq");
      rdr(OFS_CARD_CTRL); check(rd[0], 1'b0, "switch cleared");
      rdr(OFS_INT_STATUS); check(rd[1], 1'b1, "trip event");
      power_off();
      $display("test start and trip done");
   endtask
   task automatic t_start_overload();
      load_ma <= 9'h096; card_in <= 1'b1;
      wr(OFS_IFACE_CTRL, 8'h02);
      wr(OFS_DCDC_CONTROL, 8'h00);
      wr(OFS_CARD_CTRL, 8'h01);
      repeat (150) @(posedge clk);
      rdr(OFS_IFACE_STATUS); check(rd, 8'h00, "overload in startup");
      #1 check(conv_ctl.enable, 1'b1, "still starting");
      // a load above the plain startup current needs boost steps
      @(posedge clk);
      load_ma <= 9'h028;
      wr(OFS_DCDC_CONTROL, 8'h10);
      repeat (60) @(posedge clk);
      rdr(OFS_IFACE_STATUS); check(rd, 8'h00, "boost one too low");
      wr(OFS_DCDC_CONTROL, 8'h20);
      poll(8'h01); check(rd, 8'h01, "ready after boost");
      wr(OFS_DCDC_CONTROL, 8'h00);
      repeat (4) @(posedge clk);
      rdr(OFS_IFACE_STATUS); check(rd, 8'h01, "boost stepped back");
      power_off();
      $display("test startup overload done");
   endtask
   task automatic t_window_removal();
      start_ok();
      @(posedge clk);
      out_fault <= 1'b1;
      poll(8'h00);
      check(rd, 8'h00, "out of window");
      @(posedge clk);
      out_fault <= 1'b0;
      poll(8'h01);
      check(rd, 8'h01, "back in window");
      @(posedge clk);
      card_in <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check(conv_ctl.enable, 1'b0, "removal shutdown");
      rdr(OFS_INT_STATUS); check(rd[2], 1'b1, "removal event");
      rdr(OFS_CARD_CTRL); check(rd[0], 1'b0, "switch cleared on removal");
      power_off();
      $display("test window and removal done");
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test();
   end
   initial begin
      clk = 1'b0; resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 8'h00; card_in = 1'b0; out_fault = 1'b0; load_ma = 9'h000;
      fails = 0; checks = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_no_card();
      t_fields();
      t_start_tick();
      t_start_overload();
      t_window_removal();
      end_of_test();
   end
endmodule
`default_nettype wire
